// file: hw/wdt_pkg.sv
// Package: constants and decode helpers for the watchdog block
package wdt_pkg;

  // ************************************
  // Clocking
  // ************************************
  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  localparam int unsigned LF_FREQ_HZ  = 32_768;
  // aclk cycles per low-frequency oscillator period (rounded down)
  localparam int unsigned LF_DIV      = CLK_FREQ_HZ / LF_FREQ_HZ;

  // ************************************
  // Register byte addresses
  // ************************************
  localparam logic [31:0] LOAD_ADDR    = 32'h4000_2580;
  localparam logic [31:0] COUNT_ADDR   = 32'h4000_2584;
  localparam logic [31:0] CTRL_ADDR    = 32'h4000_2588;
  localparam logic [31:0] RESTART_ADDR = 32'h4000_258c;
  localparam logic [31:0] STATUS_ADDR  = 32'h4000_2598;

  // ************************************
  // Reset values and fields
  // ************************************
  localparam logic [15:0] LOAD_RST     = 16'h1000;
  localparam logic [15:0] COUNT_RST    = 16'h1000;
  localparam logic [15:0] CTRL_RST     = 16'h00e9;
  localparam logic [15:0] CTRL_RW_MASK = 16'h006f;
  localparam logic [15:0] CTRL_RO_ONES = 16'h0080;
  localparam logic [15:0] WRAP_VALUE   = 16'h1000;
  localparam logic [15:0] RESTART_KEY  = 16'hcccc;
  localparam int unsigned CTRL_MODE_BIT = 6;
  localparam int unsigned CTRL_EN_BIT   = 5;
  localparam int unsigned CTRL_PRE_LSB  = 2;
  localparam int unsigned CTRL_IRQ_BIT  = 1;
  localparam int unsigned CTRL_HOLD_BIT = 0;
  localparam int unsigned STA_LOCK_BIT  = 4;
  localparam int unsigned STA_CON_BIT   = 3;
  localparam int unsigned STA_LD_BIT    = 2;
  localparam int unsigned STA_CLRI_BIT  = 1;
  localparam int unsigned STA_IRQ_BIT   = 0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Prescaler terminal count: divide by 1, 16, 256, 4096
  function automatic logic [11:0] wdt_pre_last(input logic [1:0] pre);
    case (pre)
      2'h0:    wdt_pre_last = 12'h000;
      2'h1:    wdt_pre_last = 12'h00f;
      2'h2:    wdt_pre_last = 12'h0ff;
      default: wdt_pre_last = 12'hfff;
    endcase
  endfunction : wdt_pre_last

endpackage : wdt_pkg

// file: hw/wdt_tick_gen.sv
// Low-frequency tick generator and count prescaler for the watchdog
`timescale 1ns/1ps
module wdt_tick_gen
  import wdt_pkg::*;
#(
  parameter int unsigned DIV = wdt_pkg::LF_DIV
)(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  input  wire logic       clear,
  input  wire logic [1:0] pre,
  output logic            lf_tick,
  output logic            cnt_tick
);

  localparam logic [11:0] DIV_LAST = 12'(DIV - 1);

  logic [11:0] div_r;
  logic [11:0] div_nxt;
  logic [11:0] pre_r;
  logic [11:0] pre_nxt;

  // ************************************
  // Oscillator tick and prescaler
  // ************************************

  // Oscillator runs at all times outside reset
  always_comb
  begin
    lf_tick  = (div_r == DIV_LAST);
    div_nxt  = lf_tick ? 12'h000 : div_r + 12'h001;
    cnt_tick = 1'b0;
    pre_nxt  = pre_r;
    if (clear)
    begin
      pre_nxt = 12'h000;
    end
    else if (lf_tick && run)
    begin
      // Count tick once per selected number of oscillator ticks
      if (pre_r >= wdt_pre_last(pre))
      begin
        cnt_tick = 1'b1;
        pre_nxt  = 12'h000;
      end
      else
      begin
        pre_nxt = pre_r + 12'h001;
      end
    end
  end

  // Registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_r <= 12'h000;
      pre_r <= 12'h000;
    end
    else
    begin
      div_r <= div_nxt;
      pre_r <= pre_nxt;
    end
  end

  tick_spacing_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lf_tick |=> !lf_tick)
    else $error("oscillator tick not a single pulse");

  tick_gated_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_tick |-> lf_tick && run)
    else $error("count tick outside oscillator tick");

endmodule : wdt_tick_gen

// file: hw/wdt_watchdog.sv
// Watchdog timer: AXI4-Lite registers, 16-bit down-counter, restart key
//
// Notes on behaviour
// - Control bit 6 set means periodic mode, clear means free-running.
// - Free-running mode reloads 0x1000 on wrap, not the load value.
// - Control bit 5 enables counting; clear stops the counter.
// - Bits 3:2 select prescale 1, 16, 256 or 4096.
// - Bit 1 clear: timeout resets the device; set: timeout interrupts.
// - Interrupt on timeout only in active mode, never in hibernate.
// - Bit 0 clear: counter keeps counting during hibernate.
// - Bit 0 set: counter holds in hibernate, resumes from held count.
// - Writing 0xcccc to restart register reloads counter and clears interrupt.
// - Any other restart value triggers an immediate watchdog reset.
// - Restart register is write-only and reads as zero.
// - Control resets to 0x00e9; reserved bits read-only.
// - Counter is clocked from the oscillator always, except in reset.
// - 16-bit down-counter fed through the prescaler.
// - Setting enable locks control and load until device reset.
// - Key restart acts only after reaching the counter's tick domain.
`timescale 1ns/1ps
module wdt_watchdog
  import wdt_pkg::*;
#(
  parameter int unsigned DIV = wdt_pkg::LF_DIV
)(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        hibernate,
  output logic             wdt_irq,
  output logic             wdt_reset_req
);

  import wdt_pkg::*;

  // Merge a 16-bit register with byte-enabled write data
  function automatic logic [15:0] wmerge(input logic [15:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
    wmerge[7:0]  = strb[0] ? data[7:0]  : old[7:0];
    wmerge[15:8] = strb[1] ? data[15:8] : old[15:8];
  endfunction : wmerge

  // Address match on a word-aligned register address
  function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
    hit = (a[31:2] == r[31:2]);
  endfunction : hit

  // ************************************
  // Declarations
  // ************************************
  logic        aw_held_r, aw_held_nxt;
  logic        w_held_r,  w_held_nxt;
  logic [31:0] awaddr_r,  awaddr_nxt;
  logic [31:0] wdata_r,   wdata_nxt;
  logic [3:0]  wstrb_r,   wstrb_nxt;
  logic        bvalid_r,  bvalid_nxt;
  logic [1:0]  bresp_r,   bresp_nxt;
  logic        rvalid_r,  rvalid_nxt;
  logic [31:0] rdata_r,   rdata_nxt;
  logic [1:0]  rresp_r,   rresp_nxt;
  logic [15:0] ctrl_r,    ctrl_nxt;
  logic [15:0] load_r,    load_nxt;
  logic        lock_r,    lock_nxt;
  logic        con_sy_r,  con_sy_nxt;
  logic        ld_sy_r,   ld_sy_nxt;
  logic        clri_sy_r, clri_sy_nxt;
  logic [15:0] ctrl_lf_r, ctrl_lf_nxt;
  logic [15:0] load_lf_r, load_lf_nxt;
  logic [15:0] cnt_r,     cnt_nxt;
  logic        irq_r,     irq_nxt;
  logic        rst_r,     rst_nxt;
  logic        hib_m_r,   hib_s_r;
  logic        do_wr;
  logic        ar_fire;
  logic        wr_ctrl, wr_load, wr_key;
  logic [15:0] key_val;
  logic        bad_key;
  logic        lf_tick, cnt_tick;
  logic        run, irq_mode, restart, tmo;
  logic [15:0] reload;

  // ************************************
  // AXI4-Lite slave
  // ************************************

  // Channel handshakes
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign ar_fire       = s_axi_arvalid && !rvalid_r;
  assign do_wr         = aw_held_r && w_held_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // Write decode; lock blocks control and load writes
  assign wr_ctrl = do_wr && hit(awaddr_r, CTRL_ADDR) && !lock_r;
  assign wr_load = do_wr && hit(awaddr_r, LOAD_ADDR) && !lock_r;
  assign wr_key  = do_wr && hit(awaddr_r, RESTART_ADDR);
  assign key_val = wmerge(16'h0000, wdata_r, wstrb_r);
  assign bad_key = wr_key && (key_val != RESTART_KEY);

  // Write and read channel next state
  always_comb
  begin
    aw_held_nxt = aw_held_r;
    w_held_nxt  = w_held_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
    end
    if (do_wr)
    begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = (hit(awaddr_r, CTRL_ADDR) || hit(awaddr_r, LOAD_ADDR) ||
                     hit(awaddr_r, COUNT_ADDR) || hit(awaddr_r, RESTART_ADDR) ||
                     hit(awaddr_r, STATUS_ADDR)) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid_r && s_axi_bready)
    begin
      bvalid_nxt = 1'b0;
    end
    if (ar_fire)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      rdata_nxt  = 32'h0000_0000;   // Restart register reads zero
      if (hit(s_axi_araddr, LOAD_ADDR))
        rdata_nxt[15:0] = load_r;
      else if (hit(s_axi_araddr, COUNT_ADDR))
        rdata_nxt[15:0] = cnt_r;
      else if (hit(s_axi_araddr, CTRL_ADDR))
        rdata_nxt[15:0] = ctrl_r;
      else if (hit(s_axi_araddr, STATUS_ADDR))
      begin
        rdata_nxt[STA_LOCK_BIT] = lock_r;
        rdata_nxt[STA_CON_BIT]  = con_sy_r;
        rdata_nxt[STA_LD_BIT]   = ld_sy_r;
        rdata_nxt[STA_CLRI_BIT] = clri_sy_r;
        rdata_nxt[STA_IRQ_BIT]  = irq_r;
      end
      else if (!hit(s_axi_araddr, RESTART_ADDR))
        rresp_nxt = RESP_SLVERR;
    end
    else if (rvalid_r && s_axi_rready)
    begin
      rvalid_nxt = 1'b0;
    end
  end

  // Bus registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= 32'h0000_0000;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= RESP_OKAY;
    end
    else
    begin
      aw_held_r <= aw_held_nxt;
      w_held_r  <= w_held_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  // ************************************
  // Configuration and crossing flags
  // ************************************

  // Software copies, lock and sync-pending flags; set wins over clear
  always_comb
  begin
    ctrl_nxt    = ctrl_r;
    load_nxt    = load_r;
    lock_nxt    = lock_r;
    con_sy_nxt  = con_sy_r && !lf_tick;
    ld_sy_nxt   = ld_sy_r && !lf_tick;
    clri_sy_nxt = clri_sy_r && !lf_tick;
    ctrl_lf_nxt = lf_tick ? ctrl_r : ctrl_lf_r;
    load_lf_nxt = lf_tick ? load_r : load_lf_r;
    if (wr_ctrl)
    begin
      ctrl_nxt   = (wmerge(ctrl_r, wdata_r, wstrb_r) & CTRL_RW_MASK) |
                   CTRL_RO_ONES;
      lock_nxt   = ctrl_nxt[CTRL_EN_BIT];
      con_sy_nxt = 1'b1;
    end
    if (wr_load)
    begin
      load_nxt  = wmerge(load_r, wdata_r, wstrb_r);
      ld_sy_nxt = 1'b1;
    end
    if (wr_key && !bad_key)
      clri_sy_nxt = 1'b1;
  end

  // Configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r    <= CTRL_RST;
      load_r    <= LOAD_RST;
      lock_r    <= 1'b0;
      con_sy_r  <= 1'b0;
      ld_sy_r   <= 1'b0;
      clri_sy_r <= 1'b0;
      ctrl_lf_r <= CTRL_RST;
      load_lf_r <= LOAD_RST;
    end
    else
    begin
      ctrl_r    <= ctrl_nxt;
      load_r    <= load_nxt;
      lock_r    <= lock_nxt;
      con_sy_r  <= con_sy_nxt;
      ld_sy_r   <= ld_sy_nxt;
      clri_sy_r <= clri_sy_nxt;
      ctrl_lf_r <= ctrl_lf_nxt;
      load_lf_r <= load_lf_nxt;
    end
  end

  // Hibernate indication, two-flop synchroniser
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hib_m_r <= 1'b0;
      hib_s_r <= 1'b0;
    end
    else
    begin
      hib_m_r <= hibernate;
      hib_s_r <= hib_m_r;
    end
  end

  // ************************************
  // Counter
  // ************************************

  // Run, mode and restart terms
  assign run      = ctrl_lf_r[CTRL_EN_BIT] &&
                    !(hib_s_r && ctrl_lf_r[CTRL_HOLD_BIT]);
  assign irq_mode = ctrl_lf_r[CTRL_IRQ_BIT] && !hib_s_r;
  assign restart  = lf_tick && clri_sy_r;
  assign reload   = ctrl_lf_r[CTRL_MODE_BIT] ? load_lf_r : WRAP_VALUE;

  wdt_tick_gen #(
    .DIV      (DIV)
  ) u_tick (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (run),
    .clear    (restart),
    .pre      (ctrl_lf_r[CTRL_PRE_LSB +: 2]),
    .lf_tick  (lf_tick),
    .cnt_tick (cnt_tick)
  );

  // Down-count, timeout and outcome
  always_comb
  begin
    cnt_nxt = cnt_r;
    tmo     = 1'b0;
    if (restart)
      cnt_nxt = reload;
    else if (cnt_tick)
    begin
      if (cnt_r == 16'h0000)
      begin
        tmo     = 1'b1;
        cnt_nxt = reload;
      end
      else
        cnt_nxt = cnt_r - 16'h0001;
    end
    // A same-cycle restart blocks the timeout, so the restart clear wins
    irq_nxt = (tmo && irq_mode) || (irq_r && !restart);
    rst_nxt = (tmo && !irq_mode) || bad_key;
  end

  // Counter registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_r <= COUNT_RST;
      irq_r <= 1'b0;
      rst_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      irq_r <= irq_nxt;
      rst_r <= rst_nxt;
    end
  end

  assign wdt_irq       = irq_r;
  assign wdt_reset_req = rst_r;

  // ************************************
  // Assertions
  // ************************************
  sequence s_key_write;
    wr_key && !bad_key;
  endsequence

  sequence s_sync_apply;
    clri_sy_r && lf_tick;
  endsequence

  mode_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tmo && !restart && ctrl_lf_r[CTRL_MODE_BIT] |=> cnt_r == $past(load_lf_r))
    else $error("periodic timeout did not reload load value");

  wrap_value_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tmo && !restart && !ctrl_lf_r[CTRL_MODE_BIT] |=> cnt_r == WRAP_VALUE)
    else $error("free-running wrap not at 0x1000");

  stop_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !run && !restart |=> $stable(cnt_r))
    else $error("counter moved while stopped or held");

  timeout_path_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tmo |=> (wdt_irq == $past(irq_mode)) && (wdt_reset_req == !$past(irq_mode)))
    else $error("timeout took the wrong outcome");

  key_restart_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_sync_apply |=> cnt_r == $past(reload))
    else $error("key write did not restart counter");

  key_pending_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_key_write ##0 !lf_tick |=> clri_sy_r && $stable(cnt_r))
    else $error("key restart not held for tick domain");

  bad_key_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bad_key |=> wdt_reset_req)
    else $error("bad restart value gave no reset");

  read_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_fire && hit(s_axi_araddr, RESTART_ADDR) |=> s_axi_rdata == 32'h0000_0000)
    else $error("restart register read not zero");

  ctrl_reset_a: assert property (@(posedge aclk)
    !aresetn |=> ctrl_r == CTRL_RST)
    else $error("control reset value wrong");

  lock_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lock_r |=> lock_r && $stable(ctrl_r) && $stable(load_r))
    else $error("locked register changed");

  hib_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tmo && hib_s_r |=> wdt_reset_req)
    else $error("timeout in hibernate did not reset");

endmodule : wdt_watchdog

// file: testbench/wdt_watchdog_tb.sv
// Self-checking bench for the watchdog control and restart block
`timescale 1ns/1ps
module wdt_watchdog_tb
  import wdt_pkg::*;
;
  // ************************************
  // Signals and design instance
  // ************************************
  localparam int DV = 4;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, hibernate, wdt_irq, wdt_reset_req;
  logic        irq_seen;
  logic [31:0] awaddr, wdata, araddr, rdata, d, c1, c2, c3;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [15:0] v, ld;
  logic [34:0] e;
  logic [34:0] exp_q[$];
  logic [1:0]  bq[$];
  longint      pt[$];
  longint      per[4];
  longint      cyc;
  int          n_errors, comparisons, n0;

  wdt_watchdog #(.DIV(DV)) uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .hibernate(hibernate), .wdt_irq(wdt_irq), .wdt_reset_req(wdt_reset_req));

  // 100 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ************************************
  // Checking and monitors
  // ************************************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    comparisons++;
    if (seen !== ex)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, ex, seen);
    end
  endtask : check

  // Answer monitor: oldest note against each bus response
  always @(posedge aclk)
  begin
    if (aresetn && rvalid && rready && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      if (e[34])
      begin
        check("rresp", {30'h0, rresp}, {30'h0, e[33:32]});
        check("rdata", rdata, e[31:0]);
      end
    end
    if (aresetn && bvalid && bready && bq.size() > 0)
      check("bresp", {30'h0, bresp}, {30'h0, bq.pop_front()});
  end

  // Cycle count, reset pulse times, interrupt sightings
  always @(posedge aclk)
  begin
    cyc++;
    if (aresetn && wdt_reset_req)
      pt.push_back(cyc);
    if (aresetn && wdt_irq)
      irq_seen = 1'b1;
  end

  // ************************************
  // Bus and sequencing tasks
  // ************************************
  task automatic rd(input logic [31:0] a, input logic [31:0] ed,
                    input logic [1:0] er = RESP_OKAY, input logic chk = 1'b1);
    exp_q.push_back({chk, er, ed});
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
  endtask : rd

  task automatic wr(input logic [31:0] a, input logic [15:0] dv,
                    input logic [3:0] s = 4'h3, input logic [1:0] er = RESP_OKAY);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    bq.push_back(er);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {16'h0, dv};
    wstrb   <= s;
    wvalid  <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (awready && !aw_ok)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !w_ok)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
  endtask : wr

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    pt.delete();
    irq_seen = 1'b0;
  endtask : do_reset

  // Long enough for control, load or restart to reach the count side
  task automatic settle();
    repeat (2 * DV + 2) @(posedge aclk);
  endtask : settle

  task automatic results();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  // ************************************
  // Scenarios
  // ************************************
  initial
  begin
    {awaddr, wdata, araddr, wstrb, awvalid, wvalid, arvalid, hibernate} = '0;
    aresetn = 1'b0;
    rready = 1'b1;
    bready = 1'b1;
    n_errors = 0;
    comparisons = 0;
    cyc = 0;
    irq_seen = 1'b0;
    void'($urandom(32'h09b50b6e));
    do_reset();
    // Reset values, write-only restart, unmapped place
    rd(CTRL_ADDR, 32'h00e9);
    rd(LOAD_ADDR, 32'h1000);
    rd(COUNT_ADDR, 32'h1000);
    rd(STATUS_ADDR, 32'h0);
    rd(RESTART_ADDR, 32'h0);
    rd(32'h4000_2590, 32'h0, RESP_SLVERR);
    wr(32'h4000_2594, 16'h0, 4'h3, RESP_SLVERR);
    // Disabled timer keeps its count
    wr(CTRL_ADDR, 16'h0000);
    repeat (300 * DV) @(posedge aclk);
    rd(COUNT_ADDR, 32'h1000);
    // Random control values with enable clear, reserved bits fixed
    repeat (6)
    begin
      v = 16'($urandom);
      v[5] = 1'b0;
      wr(CTRL_ADDR, v);
      rd(CTRL_ADDR, {16'h0, (v & CTRL_RW_MASK) | CTRL_RO_ONES});
    end
    // Leave interrupt mode before any restart write
    wr(CTRL_ADDR, 16'h0000);
    // Wrong words and partial strobes force a reset, the key does not
    for (int i = 0; i < 4; i++)
    begin
      n0 = pt.size();
      wr(RESTART_ADDR, (i == 0) ? 16'h1234 : RESTART_KEY, (i == 0) ? 4'h3 : 4'(i));
      repeat (2) @(posedge aclk);
      check("reset pulses", 32'(pt.size() - n0), {31'h0, i != 3});
    end
    // Restart reload per mode, then lock of control and load
    for (int m = 0; m < 2; m++)
    begin
      do_reset();
      ld = 16'($urandom_range(16'h0fff, 2));
      wr(LOAD_ADDR, ld);
      wr(CTRL_ADDR, (m == 1) ? 16'h006c : 16'h002c);
      settle();
      wr(RESTART_ADDR, RESTART_KEY);
      settle();
      rd(COUNT_ADDR, {16'h0, (m == 1) ? ld : WRAP_VALUE});
      rd(STATUS_ADDR, 32'h10);
      wr(CTRL_ADDR, 16'h0000);
      wr(LOAD_ADDR, 16'h0003);
      settle();
      rd(CTRL_ADDR, (m == 1) ? 32'hec : 32'hac);
      rd(LOAD_ADDR, {16'h0, ld});
    end
    // Count in hibernate: runs with hold clear, freezes and resumes with it set
    for (int h = 0; h < 2; h++)
    begin
      do_reset();
      wr(LOAD_ADDR, 16'h0400);
      wr(CTRL_ADDR, 16'h0060 | 16'(h));
      settle();
      wr(RESTART_ADDR, RESTART_KEY);
      settle();
      hibernate <= 1'b1;
      repeat (4) @(posedge aclk);
      rd(COUNT_ADDR, 32'h0, RESP_OKAY, 1'b0);
      c1 = d;
      repeat (10 * DV) @(posedge aclk);
      rd(COUNT_ADDR, 32'h0, RESP_OKAY, 1'b0);
      c2 = d;
      hibernate <= 1'b0;
      check("count held", {31'h0, c1 == c2}, {31'h0, h == 1});
      repeat (10 * DV) @(posedge aclk);
      rd(COUNT_ADDR, 32'h0, RESP_OKAY, 1'b0);
      c3 = d;
      check("count resumed", {31'h0, (c2 - c3) >= 8 && (c2 - c3) <= 12}, 32'h1);
    end
    // Timeout period for each prescaler setting, reset mode
    for (int p = 0; p < 4; p++)
    begin
      do_reset();
      wr(LOAD_ADDR, 16'h0001);
      wr(CTRL_ADDR, 16'h0060 | 16'(p << 2));
      settle();
      wr(RESTART_ADDR, RESTART_KEY);
      pt.delete();
      while (pt.size() < 2) @(posedge aclk);
      per[p] = pt[1] - pt[0];
      check("timeout period", 32'(per[p]), 32'(per[0] << (4 * p)));
    end
    check("irq in reset mode", {31'h0, irq_seen}, 32'h0);
    check("base period", {31'h0, per[0] == DV || per[0] == 2 * DV}, 32'h1);
    // Interrupt mode: raise, clear by key, reset instead while hibernating
    do_reset();
    wr(LOAD_ADDR, 16'h0001);
    wr(CTRL_ADDR, 16'h0066);
    settle();
    wr(RESTART_ADDR, RESTART_KEY);
    while (!wdt_irq) @(posedge aclk);
    check("reset pulses", 32'(pt.size()), 32'h0);
    wr(RESTART_ADDR, RESTART_KEY);
    repeat (3 * DV + 4) @(posedge aclk);
    check("irq", {31'h0, wdt_irq}, 32'h0);
    hibernate <= 1'b1;
    while (pt.size() == 0) @(posedge aclk);
    repeat (2) @(posedge aclk);
    check("irq in hibernate", {31'h0, wdt_irq}, 32'h0);
    hibernate <= 1'b0;
    results();
  end

  // Watchdog against a hung wait
  initial
  begin
    repeat (90000) @(posedge aclk);
    n_errors++;
    results();
  end

endmodule : wdt_watchdog_tb
